// ---- logic/correlator_magnitude_regs.sv ----
// Frame buffer with correlator magnitude window behind an Avalon slave
//
// The implementer's own choice: register access over Avalon-MM.
`timescale 1ns/1ns
module correlator_magnitude_regs (
  input wire logic clk_i,
  input wire logic arst_n_i,
  input wire logic [flight_time_pkg::ADDR_W-1:0] avs_address_i,
  input wire logic avs_read_i,
  input wire logic avs_write_i,
  input wire logic [31:0] avs_writedata_i,
  input wire logic [3:0] avs_byteenable_i,
  output logic [31:0] avs_readdata_o,
  output logic avs_waitrequest_o,
  input wire logic [7:0] mag_i,
  input wire logic sync_detect_i,
  input wire flight_time_pkg::rx_byte_t rx_i,
  output logic flight_time_meas_enable_o
);
  import flight_time_pkg::*;

  logic ack;
  logic [7:0] idx;
  logic rd_first;
  logic wr_fire;
  logic sample_en;
  corr_set_t cap_set;
  logic cap_valid;
  logic cap_fire;
  logic [7:0] fbuf [FB_DEPTH];
  logic [TAPS-1:0][7:0] win_view;
  logic [TAPS-1:0][7:0] prev_cap;
  logic result_ready;
  logic overwritten;
  logic long_frame;
  logic rx_hits_window;
  logic rx_too_long;
  logic [7:0] next_rdata;

  // Sample clock enable for the correlator history
  sample_rate_div #(
    .DIV(SAMPLE_CYCLES)
  ) u_div (
    .clk_i(clk_i),
    .arst_n_i(arst_n_i),
    .sample_en_o(sample_en)
  );

  // History and snapshot of the magnitudes around the peak
  corr_window u_win (
    .clk_i(clk_i),
    .arst_n_i(arst_n_i),
    .sample_en_i(sample_en),
    .mag_i(mag_i),
    .sync_detect_i(sync_detect_i),
    .set_o(cap_set),
    .set_valid_o(cap_valid)
  );

  // Snapshots are dropped while the mode is off
  assign cap_fire = cap_valid && flight_time_meas_enable_o;

  // Bus decode: one wait cycle per access, byte address over four
  assign idx = avs_address_i[ADDR_W-1:2];
  assign avs_waitrequest_o = (avs_read_i || avs_write_i) && !ack;
  assign rd_first = avs_read_i && !ack;
  assign wr_fire = avs_write_i && ack;

  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      ack <= 1'b0;
    end else begin
      ack <= (avs_read_i || avs_write_i) && !ack;
    end
  end

  // Receiver writes at or above the first stored result slot, or past the usable length
  assign rx_hits_window = rx_i.valid && flight_time_meas_enable_o &&
                          ({1'b0, rx_i.index} >= IDX_MAG_MINUS_1000);
  assign rx_too_long = rx_i.valid && flight_time_meas_enable_o &&
                       ({1'b0, rx_i.index} >= 8'(USABLE_OCTETS));

  // Frame buffer entries; window slots take the snapshot first,
  // then received octets, then bus writes that are not read-only
  genvar k;
  generate
    for (k = 0; k < FB_DEPTH; k++) begin : g_fb
      localparam bit IN_WIN = (k >= int'(IDX_MAG_MINUS_1000)) &&
                              (k <= int'(IDX_MAG_PLUS_1000));
      localparam int SLOT =
        IN_WIN ? k - int'(IDX_MAG_MINUS_1000) : 0;
      logic bus_hit;
      assign bus_hit = wr_fire && (idx == 8'(k)) && avs_byteenable_i[0] &&
                       !(IN_WIN && flight_time_meas_enable_o);
      always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
          fbuf[k] <= MAG_RESET;
        end else if (IN_WIN && cap_fire) begin
          fbuf[k] <= cap_set.mag[SLOT];
        end else if (rx_i.valid && (rx_i.index == 7'(k))) begin
          fbuf[k] <= rx_i.data;
        end else if (bus_hit) begin
          fbuf[k] <= avs_writedata_i[7:0];
        end
      end
      if (IN_WIN) begin : g_view
        assign win_view[SLOT] = fbuf[k];
      end
    end
  endgenerate

  // Mode enable; write lands on the edge where waitrequest is low
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      flight_time_meas_enable_o <= ENABLE_RESET;
    end else if (wr_fire && idx == IDX_CTRL && avs_byteenable_i[0]) begin
      flight_time_meas_enable_o <= avs_writedata_i[CTRL_ENABLE_BIT];
    end
  end

  // Sticky status, write one to clear; a new event wins over the clear
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      result_ready <= 1'b0;
      overwritten <= 1'b0;
      long_frame <= 1'b0;
    end else begin
      if (cap_fire) begin
        result_ready <= 1'b1;
      end else if (wr_fire && idx == IDX_STATUS && avs_byteenable_i[0] &&
                   avs_writedata_i[STAT_READY_BIT]) begin
        result_ready <= 1'b0;
      end
      if (rx_hits_window) begin
        overwritten <= 1'b1;
      end else if (wr_fire && idx == IDX_STATUS && avs_byteenable_i[0] &&
                   avs_writedata_i[STAT_OVERWRITE_BIT]) begin
        overwritten <= 1'b0;
      end
      if (rx_too_long) begin
        long_frame <= 1'b1;
      end else if (wr_fire && idx == IDX_STATUS && avs_byteenable_i[0] &&
                   avs_writedata_i[STAT_LONG_BIT]) begin
        long_frame <= 1'b0;
      end
    end
  end

  // Read mux; unmapped indices read as zero
  always_comb begin
    next_rdata = 8'h00;
    if (!idx[7]) begin
      next_rdata = fbuf[idx[6:0]];
    end else if (idx == IDX_CTRL) begin
      next_rdata[CTRL_ENABLE_BIT] = flight_time_meas_enable_o;
    end else if (idx == IDX_STATUS) begin
      next_rdata[STAT_READY_BIT] = result_ready;
      next_rdata[STAT_OVERWRITE_BIT] = overwritten;
      next_rdata[STAT_LONG_BIT] = long_frame;
    end
  end

  // Read data is captured in the wait cycle so it stands at the ack edge
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      avs_readdata_o <= 32'h0000_0000;
    end else if (rd_first) begin
      avs_readdata_o <= {24'h00_0000, next_rdata};
    end
  end

  // Assertion helper: the snapshot of the previous cycle
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      prev_cap <= '0;
    end else begin
      prev_cap <= cap_set.mag;
    end
  end

  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (!arst_n_i);

  sequence s_read_first;
    avs_read_i && avs_waitrequest_o;
  endsequence

  sequence s_capture;
    cap_valid && flight_time_meas_enable_o;
  endsequence

  sequence s_write_first;
    avs_write_i && avs_waitrequest_o;
  endsequence

  // Exactly one wait cycle, then the held request completes
  property p_one_wait;
    s_read_first ##1 avs_read_i |-> !avs_waitrequest_o;
  endproperty
  a_one_wait: assert property (p_one_wait)
    else $error("read not acknowledged after one wait cycle");

  // Whole window including both edges changes in one cycle
  property p_capture_all;
    s_capture |=> win_view == prev_cap;
  endproperty
  a_capture_all: assert property (p_capture_all)
    else $error("snapshot not stored as one set");

  // With the mode off a snapshot leaves the window alone
  property p_disabled_ignores;
    cap_valid && !flight_time_meas_enable_o && !rx_i.valid && !avs_write_i
      |=> $stable(win_view);
  endproperty
  a_disabled_ignores: assert property (p_disabled_ignores)
    else $error("window changed while mode disabled");

  // Bus writes cannot alter the window while enabled
  property p_window_ro;
    wr_fire && flight_time_meas_enable_o && !cap_valid && !rx_i.valid
      |=> $stable(win_view);
  endproperty
  a_window_ro: assert property (p_window_ro)
    else $error("read-only window written by bus");

  // Slots 750 and 500 ns before the peak
  property p_before_peak;
    s_capture |=> win_view[1] == prev_cap[1] && win_view[2] == prev_cap[2]
      && fbuf[IDX_MAG_MINUS_750[6:0]] == prev_cap[1];
  endproperty
  a_before_peak: assert property (p_before_peak)
    else $error("minus 750/500 ns slots wrong");

  property p_minus_250;
    s_capture |=> fbuf[IDX_MAG_MINUS_250[6:0]] == prev_cap[PEAK_SLOT-1];
  endproperty
  a_minus_250: assert property (p_minus_250)
    else $error("minus 250 ns slot wrong");

  property p_at_peak;
    s_capture |=> fbuf[IDX_MAG_AT_PEAK[6:0]] == prev_cap[PEAK_SLOT];
  endproperty
  a_at_peak: assert property (p_at_peak)
    else $error("peak slot wrong");

  property p_after_peak;
    s_capture |=> fbuf[IDX_MAG_PLUS_250[6:0]] == prev_cap[5] &&
      fbuf[IDX_MAG_PLUS_500[6:0]] == prev_cap[6] &&
      fbuf[IDX_MAG_PLUS_750[6:0]] == prev_cap[7];
  endproperty
  a_after_peak: assert property (p_after_peak)
    else $error("plus 250/500/750 ns slots wrong");

  // Long frames overwrite results and raise the flag
  property p_overwrite;
    rx_hits_window && !cap_valid |=> overwritten &&
      fbuf[$past(rx_i.index)] == $past(rx_i.data);
  endproperty
  a_overwrite: assert property (p_overwrite)
    else $error("long frame overwrite not recorded");

  // Read of the peak slot returns that byte, upper bits zero
  property p_read_slot;
    s_read_first ##0 (idx == IDX_MAG_AT_PEAK) ##1 avs_read_i
      |-> avs_readdata_o == {24'h00_0000, win_view[PEAK_SLOT]};
  endproperty
  a_read_slot: assert property (p_read_slot)
    else $error("read of peak slot returned wrong data");

  // Unmapped addresses read as zero
  property p_unmapped;
    s_read_first ##0 (idx > IDX_STATUS) |=> avs_readdata_o == 32'h0;
  endproperty
  a_unmapped: assert property (p_unmapped)
    else $error("unmapped read not zero");

  // Writes see the same single wait cycle as reads
  property p_write_one_wait;
    s_write_first ##1 avs_write_i |-> !avs_waitrequest_o;
  endproperty
  a_write_one_wait: assert property (p_write_one_wait)
    else $error("write not acknowledged after one wait cycle");

  // An idle bus never stalls the master
  property p_idle_no_wait;
    !avs_read_i && !avs_write_i |-> !avs_waitrequest_o;
  endproperty
  a_idle_no_wait: assert property (p_idle_no_wait)
    else $error("waitrequest high with no request");

  // One byte per word; the upper read bits never carry data
  property p_upper_zero;
    avs_readdata_o[31:8] == 24'h00_0000;
  endproperty
  a_upper_zero: assert property (p_upper_zero)
    else $error("read data upper bits not zero");

  // A stored set is flagged to software at once
  property p_ready_set;
    s_capture |=> result_ready;
  endproperty
  a_ready_set: assert property (p_ready_set)
    else $error("result ready not set after snapshot");

  // A dropped snapshot must not claim a result either
  property p_disabled_no_ready;
    cap_valid && !flight_time_meas_enable_o && !result_ready
      |=> !result_ready;
  endproperty
  a_disabled_no_ready: assert property (p_disabled_no_ready)
    else $error("result ready set while mode disabled");

  // Control write lands at the accepting edge
  property p_enable_write;
    wr_fire && idx == IDX_CTRL && avs_byteenable_i[0]
      |=> flight_time_meas_enable_o ==
          $past(avs_writedata_i[CTRL_ENABLE_BIT]);
  endproperty
  a_enable_write: assert property (p_enable_write)
    else $error("mode enable write not applied");

  // Masked writes leave the mode alone
  property p_masked_write;
    wr_fire && !avs_byteenable_i[0] |=> $stable(flight_time_meas_enable_o);
  endproperty
  a_masked_write: assert property (p_masked_write)
    else $error("masked write changed mode enable");

  // With the mode off a window slot is an ordinary buffer byte
  property p_disabled_write;
    wr_fire && !flight_time_meas_enable_o && idx == IDX_MAG_MINUS_750 &&
      avs_byteenable_i[0] && !rx_i.valid
      |=> fbuf[IDX_MAG_MINUS_750[6:0]] == $past(avs_writedata_i[7:0]);
  endproperty
  a_disabled_write: assert property (p_disabled_write)
    else $error("bus write to slot lost while mode disabled");

  // Any octet past the usable length is reported while the mode is on
  property p_long_flag;
    rx_too_long |=> long_frame;
  endproperty
  a_long_flag: assert property (p_long_flag)
    else $error("long frame flag not set");
endmodule

// ---- logic/flight_time_pkg.sv ----
// Shared constants and carrier types of the correlator magnitude bank
package flight_time_pkg;
  // Clock and sample spacing of the correlator output
  localparam int unsigned CLK_PERIOD_NS = 10;
  localparam int unsigned SAMPLE_SPACING_NS = 250;
  localparam int unsigned SAMPLE_CYCLES = SAMPLE_SPACING_NS / CLK_PERIOD_NS;
  // Nine taps from -1000 ns to +1000 ns, four of them after the peak
  localparam int unsigned TAPS = 9;
  localparam int unsigned SAMPLES_AFTER_PEAK = 4;
  localparam int unsigned PEAK_SLOT = 4;
  localparam int unsigned FB_DEPTH = 128;
  localparam int unsigned ADDR_W = 10;
  localparam int unsigned USABLE_OCTETS = 114;
  // Register indices; byte address is four times the index
  localparam logic [7:0] IDX_MAG_MINUS_1000 = 8'h73;
  localparam logic [7:0] IDX_MAG_MINUS_750 = 8'h74;
  localparam logic [7:0] IDX_MAG_MINUS_500 = 8'h75;
  localparam logic [7:0] IDX_MAG_MINUS_250 = 8'h76;
  localparam logic [7:0] IDX_MAG_AT_PEAK = 8'h77;
  localparam logic [7:0] IDX_MAG_PLUS_250 = 8'h78;
  localparam logic [7:0] IDX_MAG_PLUS_500 = 8'h79;
  localparam logic [7:0] IDX_MAG_PLUS_750 = 8'h7a;
  localparam logic [7:0] IDX_MAG_PLUS_1000 = 8'h7b;
  localparam logic [7:0] IDX_CTRL = 8'h80;
  localparam logic [7:0] IDX_STATUS = 8'h81;
  // Field positions and reset values
  localparam int unsigned CTRL_ENABLE_BIT = 7;
  localparam int unsigned STAT_READY_BIT = 0;
  localparam int unsigned STAT_OVERWRITE_BIT = 1;
  localparam int unsigned STAT_LONG_BIT = 2;
  localparam logic [7:0] MAG_RESET = 8'h00;
  localparam logic ENABLE_RESET = 1'b0;

  // One consistent set of samples; mag[k] is (k - 4) * 250 ns from peak
  typedef struct packed {
    logic [TAPS-1:0][7:0] mag;
  } corr_set_t;

  // Received octet heading for the frame buffer
  typedef struct packed {
    logic valid;
    logic [6:0] index;
    logic [7:0] data;
  } rx_byte_t;
endpackage

// ---- logic/sample_rate_div.sv ----
// Divider giving one enable pulse per correlator sample spacing
`timescale 1ns/1ns
module sample_rate_div #(
  parameter int unsigned DIV = flight_time_pkg::SAMPLE_CYCLES
) (
  input wire logic clk_i,
  input wire logic arst_n_i,
  output logic sample_en_o
);
  import flight_time_pkg::*;

  logic [7:0] count;

  // Free-running count; pulse on wrap so the rate never drifts
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      count <= 8'h00;
    end else if (count == 8'(DIV - 1)) begin
      count <= 8'h00;
    end else begin
      count <= count + 8'h01;
    end
  end

  assign sample_en_o = (count == 8'(DIV - 1));
endmodule

// ---- logic/corr_window.sv ----
// History of correlator magnitudes and snapshot around the sync peak
`timescale 1ns/1ns
module corr_window (
  input wire logic clk_i,
  input wire logic arst_n_i,
  input wire logic sample_en_i,
  input wire logic [7:0] mag_i,
  input wire logic sync_detect_i,
  output flight_time_pkg::corr_set_t set_o,
  output logic set_valid_o
);
  import flight_time_pkg::*;

  logic [TAPS-1:0][7:0] hist;
  logic [TAPS-1:0][7:0] next_hist;
  logic [2:0] after_cnt;
  logic pending;
  logic fire;

  // Shifted history as it stands after this edge; hist[0] is newest
  always_comb begin
    next_hist = hist;
    if (sample_en_i) begin
      next_hist = {hist[TAPS-2:0], mag_i};
    end
  end

  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      hist <= '0;
    end else begin
      hist <= next_hist;
    end
  end

  // Peak is the newest sample after the sync edge; wait four more
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      pending <= 1'b0;
      after_cnt <= 3'h0;
    end else if (sync_detect_i) begin
      pending <= 1'b1;
      after_cnt <= 3'(SAMPLES_AFTER_PEAK);
    end else if (fire) begin
      pending <= 1'b0;
      after_cnt <= 3'h0;
    end else if (pending && sample_en_i) begin
      after_cnt <= after_cnt - 3'h1;
    end
  end

  assign fire = pending && sample_en_i && (after_cnt == 3'h1) &&
                !sync_detect_i;

  // Whole set is taken in one edge so software never sees a mix
  genvar k;
  generate
    for (k = 0; k < TAPS; k++) begin : g_snap
      always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
          set_o.mag[k] <= MAG_RESET;
        end else if (fire) begin
          set_o.mag[k] <= next_hist[TAPS-1-k];
        end
      end
    end
  endgenerate

  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      set_valid_o <= 1'b0;
    end else begin
      set_valid_o <= fire;
    end
  end
endmodule

// ---- dv/tb_correlator_magnitude_regs.sv ----
// Self-checking bench for the correlator magnitude register bank
`timescale 1ns/1ns
module tb_correlator_magnitude_regs;
  import flight_time_pkg::*;
  logic clk_i;
  logic arst_n_i;
  logic [ADDR_W-1:0] avs_address_i;
  logic avs_read_i;
  logic avs_write_i;
  logic [31:0] avs_writedata_i;
  logic [3:0] avs_byteenable_i;
  logic [31:0] avs_readdata_o;
  logic avs_waitrequest_o;
  logic [7:0] mag_i = 8'h00;
  logic sync_detect_i;
  rx_byte_t rx_i;
  logic flight_time_meas_enable_o;
  int err_count = 0;
  int checked = 0;
  int cyc = 0;
  logic [7:0] peak;
  logic [7:0] rd;

  correlator_magnitude_regs i_correlator_magnitude_regs (
    .clk_i(clk_i), .arst_n_i(arst_n_i),
    .avs_address_i(avs_address_i), .avs_read_i(avs_read_i),
    .avs_write_i(avs_write_i), .avs_writedata_i(avs_writedata_i),
    .avs_byteenable_i(avs_byteenable_i), .avs_readdata_o(avs_readdata_o),
    .avs_waitrequest_o(avs_waitrequest_o), .mag_i(mag_i),
    .sync_detect_i(sync_detect_i), .rx_i(rx_i),
    .flight_time_meas_enable_o(flight_time_meas_enable_o)
  );

  // 100 MHz clock
  initial begin
    clk_i = 1'b0;
    forever #5 clk_i = ~clk_i;
  end

  // Magnitude steps mid-way between sample edges, so a one-cycle
  // uncertainty in the sample phase cannot change what is captured
  always @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      cyc <= 0;
      mag_i <= 8'h00;
    end else begin
      cyc <= cyc + 1;
      if (cyc % 25 == 12) begin
        mag_i <= mag_i + 8'h1b;
      end
    end
  end

  // Verdict and end of run
  task automatic results();
    $display("checked %0d mismatches %0d", checked, err_count);
    if (err_count == 0 && checked > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  task automatic timeout(input string what);
    $display("[FAIL] %0t timeout waiting for %s", $time, what);
    err_count++;
    results();
  endtask

  task automatic chk_byte(input logic [7:0] got, input logic [7:0] exp);
    checked++;
    if (got !== exp) begin
      $display("[FAIL] %0t byte got %h exp %h", $time, got, exp);
      err_count++;
    end
  endtask

  task automatic chk_bit(input logic got, input logic exp);
    checked++;
    if (got !== exp) begin
      $display("[FAIL] %0t flag got %b exp %b", $time, got, exp);
      err_count++;
    end
  endtask

  // Looks at waitrequest where it has settled for the coming edge
  task automatic wait_ack();
    int n;
    n = 0;
    do begin
      @(negedge clk_i);
      n++;
    end while (avs_waitrequest_o !== 1'b0 && n < 50);
    if (avs_waitrequest_o !== 1'b0) begin
      timeout("waitrequest");
    end
  endtask

  // Request held until the accepting edge, released after it
  task automatic bus_rd(input logic [7:0] idx);
    avs_address_i <= {idx, 2'b00};
    avs_read_i <= 1'b1;
    wait_ack();
    // Data is taken at the accepting edge, where it still stands
    @(posedge clk_i);
    rd = avs_readdata_o[7:0];
    chk_byte(avs_readdata_o[15:8], 8'h00);
    avs_read_i <= 1'b0;
    @(posedge clk_i);
  endtask

  task automatic bus_wr(input logic [7:0] idx, input logic [7:0] d,
                        input logic [3:0] be);
    avs_address_i <= {idx, 2'b00};
    avs_writedata_i <= {24'h000000, d};
    avs_byteenable_i <= be;
    avs_write_i <= 1'b1;
    wait_ack();
    @(posedge clk_i);
    avs_write_i <= 1'b0;
    @(posedge clk_i);
  endtask

  task automatic rd_chk(input logic [7:0] idx, input logic [7:0] exp);
    bus_rd(idx);
    chk_byte(rd, exp);
  endtask

  task automatic rx_put(input logic [6:0] idx, input logic [7:0] d);
    rx_i <= '{valid: 1'b1, index: idx, data: d};
    @(posedge clk_i);
    rx_i.valid <= 1'b0;
    @(posedge clk_i);
  endtask

  // History is first filled with ramp samples, so no slot holds a reset
  // zero; sync just after a sample edge makes the peak the magnitude now
  // shown; then wait four sample spacings plus the capture latency
  task automatic pulse_sync();
    int n;
    n = 0;
    repeat (5 * SAMPLE_CYCLES) @(posedge clk_i);
    do begin
      @(negedge clk_i);
      n++;
    end while (cyc % 25 != 5 && n < 30);
    if (cyc % 25 != 5) begin
      timeout("sync slot");
    end
    peak = mag_i;
    @(posedge clk_i);
    sync_detect_i <= 1'b1;
    @(posedge clk_i);
    sync_detect_i <= 1'b0;
    repeat (4 * SAMPLE_CYCLES + 10) @(posedge clk_i);
  endtask

  task automatic t_reset();
    for (int k = 0; k < 9; k++) begin
      rd_chk(IDX_MAG_MINUS_1000 + 8'(k), MAG_RESET);
    end
    rd_chk(IDX_STATUS, 8'h00);
    chk_bit(flight_time_meas_enable_o, ENABLE_RESET);
    $display("test reset done");
  endtask

  task automatic t_window();
    logic [7:0] e;
    bus_wr(IDX_CTRL, 8'h80, 4'h1);
    chk_bit(flight_time_meas_enable_o, 1'b1);
    pulse_sync();
    for (int k = 0; k < 9; k++) begin
      e = 8'(int'(peak) + (k - 4) * 27);
      rd_chk(IDX_MAG_MINUS_1000 + 8'(k), e);
    end
    rd_chk(IDX_MAG_AT_PEAK, peak);
    bus_wr(IDX_MAG_AT_PEAK, ~peak, 4'h1);
    rd_chk(IDX_MAG_AT_PEAK, peak);
    rd_chk(IDX_STATUS, 8'h01);
    $display("test window done");
  endtask

  task automatic t_disabled();
    bus_wr(IDX_CTRL, 8'h00, 4'h1);
    chk_bit(flight_time_meas_enable_o, 1'b0);
    bus_wr(IDX_STATUS, 8'h07, 4'h1);
    bus_wr(IDX_MAG_MINUS_750, 8'h5a, 4'h1);
    pulse_sync();
    rd_chk(IDX_MAG_MINUS_750, 8'h5a);
    rd_chk(IDX_STATUS, 8'h00);
    $display("test disabled done");
  endtask

  task automatic t_overflow();
    bus_wr(IDX_CTRL, 8'h80, 4'h1);
    rx_put(7'(USABLE_OCTETS), 8'h3c);
    rd_chk(8'(USABLE_OCTETS), 8'h3c);
    rd_chk(IDX_STATUS, 8'h04);
    rx_put(7'h75, 8'hc3);
    rd_chk(IDX_MAG_MINUS_500, 8'hc3);
    rd_chk(IDX_STATUS, 8'h06);
    $display("test overflow done");
  endtask

  // Masked write, unmapped place and status clearing
  task automatic t_misc();
    bus_wr(IDX_CTRL, 8'h00, 4'h0);
    chk_bit(flight_time_meas_enable_o, 1'b1);
    bus_wr(8'h90, 8'hff, 4'h1);
    rd_chk(8'h90, 8'h00);
    bus_wr(IDX_STATUS, 8'h07, 4'h1);
    rd_chk(IDX_STATUS, 8'h00);
    $display("test misc done");
  endtask

  // Main sequence: all inputs defined at time zero, reset two cycles
  initial begin
    arst_n_i = 1'b0;
    avs_address_i = '0;
    avs_read_i = 1'b0;
    avs_write_i = 1'b0;
    avs_writedata_i = 32'h00000000;
    avs_byteenable_i = 4'h0;
    sync_detect_i = 1'b0;
    rx_i = '0;
    repeat (2) @(posedge clk_i);
    arst_n_i <= 1'b1;
    @(posedge clk_i);
    t_reset();
    t_window();
    t_disabled();
    t_overflow();
    t_misc();
    results();
  end
endmodule
